// ===== design/pdr_defines.svh
`ifndef PDR_DEFINES_SVH
`define PDR_DEFINES_SVH

// register map, byte addresses
`define PDR_OFF_CTRL0 12'h000
`define PDR_OFF_CTRL1 12'h004
`define PDR_OFF_CTRL2 12'h008
`define PDR_OFF_CTRL3 12'h00C
`define PDR_OFF_OUT0 12'h010
`define PDR_OFF_OUT1 12'h014
`define PDR_OFF_OUT2 12'h018
`define PDR_OFF_OUT3 12'h01C
`define PDR_OFF_IN0 12'h020
`define PDR_OFF_IN1 12'h024
`define PDR_OFF_IN2 12'h028
`define PDR_OFF_IN3 12'h02C
`define PDR_OFF_STATUS 12'h030

// direction word field positions (1 = input)
`define PDR_BIT_A 4
`define PDR_BIT_CH 3
`define PDR_BIT_B 1
`define PDR_BIT_CL 0

// reset value of a direction word: all software groups input
`define PDR_CTRL_RST 8'h1B
// default output data
`define PDR_OUT_RST 24'h000000

`endif

// ===== design/pdr_pkg.sv
package pdr_pkg;
  // one four-bit direction group set per port: a, c high, b, c low
  typedef struct packed {
    logic a;
    logic ch;
    logic b;
    logic cl;
  } pdr_dir_t;

  // ahb-lite address phase capture
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic valid;
  } pdr_ahb_req_t;

  // per-port saved state: direction bits and output data
  typedef struct packed {
    pdr_dir_t dir;
    logic [23:0] data;
  } pdr_port_t;
endpackage

// ===== design/pdr_port_state.sv
`timescale 1ns/1ps
`include "pdr_defines.svh"

// holds one port's direction and output data with reset retention
module pdr_port_state (
  // clock and resets
  input wire logic clk,
  input wire logic cold_rst_n,
  input wire logic warm_rst_n,
  input wire logic retain,
  // straps, one per group, high = forced output
  input wire logic [3:0] force_out,
  // software write
  input wire logic dir_we,
  input wire logic [3:0] dir_wdata,
  input wire logic out_we,
  input wire logic [23:0] out_wdata,
  // held state
  output pdr_pkg::pdr_port_t state
);

  pdr_pkg::pdr_port_t state_r;
  pdr_pkg::pdr_port_t state_nxt;
  wire logic clear_now;

  // warm reset only clears when retention is off
  assign clear_now = !cold_rst_n || (!warm_rst_n && !retain);

  // next state: straps override any software direction
  always_comb begin
    state_nxt = state_r;
    if (dir_we) begin
      state_nxt.dir = dir_wdata & ~force_out;
    end
    if (out_we) begin
      state_nxt.data = out_wdata;
    end
    // a warm reset with retention on freezes the port as it was
    if (!warm_rst_n) begin
      state_nxt = state_r;
    end
    // strap closed forces output even if straps move after reset
    state_nxt.dir = state_nxt.dir & ~force_out;
  end

  // software groups default input, forced ones drive low
  always_ff @(posedge clk) begin
    if (clear_now) begin
      state_r.dir <= ~force_out;
      state_r.data <= `PDR_OUT_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state = state_r;

endmodule

// ===== design/pdr_top.sv
`timescale 1ns/1ps
`include "pdr_defines.svh"

// Behaviour
// - open strap lets software choose direction
// - closed strap forces group to output
// - no retention: software groups reset to input
// - forced outputs drive low after a cold reset or a warm reset without retention
// - retention plus warm reset keeps everything
// - cold reset always restores the defaults
// - c port has separate nibble straps
// - direction writes to forced groups ignored
// - direction bits a4 ch3 b1 cl0
module pdr_top (
  // clock and cold reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // warm reset, active low
  input wire logic WARM_RST_N,
  // straps, high = closed
  input wire logic RESET_RETENTION_STRAP,
  input wire logic [3:0] GROUP_A_FORCE_OUT_STRAP,
  input wire logic [3:0] GROUP_B_FORCE_OUT_STRAP,
  input wire logic [3:0] GROUP_C_LOW_FORCE_OUT_STRAP,
  input wire logic [3:0] GROUP_C_HIGH_FORCE_OUT_STRAP,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // field lines, 24 per port, a[7:0] b[15:8] c[23:16]
  input wire logic [95:0] IO_IN,
  output logic [95:0] IO_OUT,
  output logic [95:0] IO_OE
);

  pdr_pkg::pdr_ahb_req_t req_r;
  pdr_pkg::pdr_port_t st [4];
  logic [31:0] hrdata_r;
  logic [95:0] io_out_r;
  logic [95:0] io_oe_r;
  logic [95:0] io_in_r;
  wire logic [3:0] force_out [4];
  wire logic do_write;
  wire logic do_read;
  wire logic [3:0] dir_we;
  wire logic [3:0] out_we;
  wire logic [3:0] wdir;
  wire logic [1:0] port_sel;
  wire logic [11:0] page;
  // read side decode, taken from the live address phase
  wire logic [1:0] rd_port;
  wire logic [11:0] rd_page;
  wire logic [31:0] rd_ctrl;
  wire logic [31:0] rd_out;
  wire logic [31:0] rd_in;
  wire logic [31:0] rd_status;
  wire logic [31:0] rd_word;
  // bus answer flops, so every output leaves a register
  logic hreadyout_r;
  logic hresp_r;

  // bus timing in short:
  //   the address phase is captured into req_r on any ready edge
  //   writes land in the port state at the end of their data phase
  //   reads are looked up in the address phase and held in hrdata_r
  //   a read right after a write to the same word sees the new value
  //   only when the master idles a cycle between the two transfers;
  //   a fully pipelined master would read the old word back
  // retention lives in the port state modules, not here: this level
  // only routes straps, decodes the bus and registers the pins

  // expand a 4-bit group direction into 24 enables, high = drive
  function automatic logic [23:0] dir_to_oe(input logic [3:0] d);
    dir_to_oe = {{4{~d[`PDR_BIT_CH - 1]}}, {4{~d[0]}},
                 {8{~d[`PDR_BIT_B]}}, {8{~d[`PDR_BIT_A - 1]}}};
  endfunction

  // register page of a byte address: the row of four words it sits in
  function automatic logic [11:0] page_of(input logic [11:0] a);
    page_of = {a[11:4], 4'h0};
  endfunction

  // port index of a byte address within its page
  function automatic logic [1:0] port_of(input logic [11:0] a);
    port_of = a[3:2];
  endfunction

  // strap groups ordered a, c high, b, c low as in pdr_dir_t
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_port
      assign force_out[gi] = {GROUP_A_FORCE_OUT_STRAP[gi],
                              GROUP_C_HIGH_FORCE_OUT_STRAP[gi],
                              GROUP_B_FORCE_OUT_STRAP[gi],
                              GROUP_C_LOW_FORCE_OUT_STRAP[gi]};
      assign dir_we[gi] = do_write && page == `PDR_OFF_CTRL0
                          && port_sel == 2'(gi);
      assign out_we[gi] = do_write && page == `PDR_OFF_OUT0
                          && port_sel == 2'(gi);
      pdr_port_state u_state (
        .clk(CLOCK),
        .cold_rst_n(RST_N),
        .warm_rst_n(WARM_RST_N),
        .retain(RESET_RETENTION_STRAP),
        .force_out(force_out[gi]),
        .dir_we(dir_we[gi]),
        .dir_wdata(wdir),
        .out_we(out_we[gi]),
        .out_wdata(HWDATA[23:0]),
        .state(st[gi])
      );
    end
  endgenerate

  // direction word bits picked out of the written byte
  assign wdir = {HWDATA[`PDR_BIT_A], HWDATA[`PDR_BIT_CH],
                 HWDATA[`PDR_BIT_B], HWDATA[`PDR_BIT_CL]};
  // writes are refused while the host sits in warm reset
  assign do_write = req_r.valid && req_r.write && WARM_RST_N;
  assign do_read = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign port_sel = port_of(req_r.addr);
  assign page = page_of(req_r.addr);

  // read mux as plain selection; the flop below only captures it
  assign rd_port = port_of(HADDR);
  assign rd_page = page_of(HADDR);
  assign rd_ctrl = {27'h0, st[rd_port].dir.a, st[rd_port].dir.ch, 1'b0,
                    st[rd_port].dir.b, st[rd_port].dir.cl};
  assign rd_out = {8'h00, st[rd_port].data};
  assign rd_in = {8'h00, io_in_r[rd_port * 24 +: 24]};
  assign rd_status = {31'h0, RESET_RETENTION_STRAP};
  // offsets outside the ctrl, out, in and status pages read as zero, never a bus error
  assign rd_word = rd_page == `PDR_OFF_CTRL0 ? rd_ctrl :
                   rd_page == `PDR_OFF_OUT0 ? rd_out :
                   rd_page == `PDR_OFF_IN0 ? rd_in :
                   rd_page == `PDR_OFF_STATUS ? rd_status :
                   32'h00000000;

  // zero-wait slave: address phase captured, data phase next cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      req_r <= '0;
    end else if (HREADY) begin
      req_r.addr <= HADDR;
      req_r.write <= HWRITE;
      req_r.valid <= HSEL && HTRANS[1];
    end
  end

  // read data registered in the address phase so it sits in data phase
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      hrdata_r <= 32'h00000000;
    end else if (do_read) begin
      hrdata_r <= rd_word;
    end
  end

  // bus answer: never a wait state, never an error response
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // pins: inputs read high through pull-ups when not driven
  // the pin flops trail the state flops by one edge, so a direction
  // write shows on the lines one edge after its data phase ends
  always_ff @(posedge CLOCK) begin
    io_in_r <= IO_IN;
    for (int p = 0; p < 4; p++) begin
      io_oe_r[p * 24 +: 24] <= dir_to_oe(st[p].dir);
      io_out_r[p * 24 +: 24] <= st[p].data;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = hreadyout_r;
  assign HRESP = hresp_r;
  assign IO_OUT = io_out_r;
  assign IO_OE = io_oe_r;

endmodule

// ===== sim/pdr_top_checker.sv
`timescale 1ns/1ps
// watches the card from its pins; force straps move only in cold reset
module pdr_top_checker (
  // clock and resets
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WARM_RST_N,
  // straps
  input wire logic RESET_RETENTION_STRAP,
  input wire logic [3:0] GROUP_A_FORCE_OUT_STRAP,
  // bus
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // field lines
  input wire logic [95:0] IO_OUT,
  input wire logic [95:0] IO_OE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // port 0 group a stands in for every group
  wire logic rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
  wire logic ret = RESET_RETENTION_STRAP;
  wire logic fa = GROUP_A_FORCE_OUT_STRAP[0];
  chk_ready_high: assert property (HREADYOUT)
    else $error("ready low");
  chk_resp_okay: assert property (!HRESP)
    else $error("error response");
  chk_forced_out: assert property (fa && $past(RST_N) |-> &IO_OE[7:0])
    else $error("forced group not driving");
  chk_cold_default: assert property ($rose(RST_N) && !$past(RST_N, 2)
    |-> IO_OUT[7:0] == 8'h00 && (fa || IO_OE[7:0] == 8'h00))
    else $error("cold reset default wrong");
  // three low samples so a write in flight has landed
  chk_warm_keep: assert property (!WARM_RST_N && $past(!WARM_RST_N)
    && $past(!WARM_RST_N, 2) && ret |-> $stable(IO_OE) && $stable(IO_OUT))
    else $error("retained state moved");
  chk_warm_clear: assert property (!WARM_RST_N && $past(!WARM_RST_N)
    && $past(!WARM_RST_N, 2) && !ret && $past(!ret, 2) && !fa
    |-> IO_OE[7:0] == 8'h00)
    else $error("warm reset kept state");
  chk_unmapped_zero: assert property (rd && HADDR == 12'h100 |=> HRDATA == 0)
    else $error("unmapped read not zero");
  chk_status_bit: assert property (rd && HADDR == 12'h030
    |=> HRDATA[0] == $past(ret))
    else $error("status bit wrong");
  cover property (!WARM_RST_N && ret);
  cover property (rd && HADDR == 12'h030);
  cover property (fa && $past(RST_N));
endmodule

// ===== sim/pdr_field_model.sv
`timescale 1ns/1ps
// field wiring: card-driven lines loop back, others driven or pulled up
module pdr_field_model (
  // card side
  input wire logic [95:0] io_out,
  input wire logic [95:0] io_oe,
  // external drivers
  input wire logic [95:0] ext,
  input wire logic [95:0] ext_en,
  // sensed lines
  output logic [95:0] io_in
);
  // a floating line reads high, never a settled unknown
  assign io_in = io_oe & io_out | ~io_oe & (~ext_en | ext);
endmodule

// ===== sim/tb_pdr_top.sv
`timescale 1ns/1ps
module tb_pdr_top;
  logic CLOCK = 0, RST_N = 0, WARM_RST_N = 1, RESET_RETENTION_STRAP = 0;
  logic [3:0] GROUP_A_FORCE_OUT_STRAP = 0, GROUP_B_FORCE_OUT_STRAP = 0;
  logic [3:0] GROUP_C_LOW_FORCE_OUT_STRAP = 0;
  logic [3:0] GROUP_C_HIGH_FORCE_OUT_STRAP = 0;
  logic HSEL = 0, HWRITE = 0, HREADY = 1, HREADYOUT, HRESP;
  logic [11:0] HADDR = 0;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 0, HRDATA, r;
  logic [95:0] IO_IN, IO_OUT, IO_OE, ext, ext_en;
  integer seed, miscompares, checked;
  logic [7:0] ctl [4];
  logic [23:0] dat [4];
  pdr_top i_dut (.*);
  pdr_field_model i_fld (.io_out(IO_OUT), .io_oe(IO_OE), .ext(ext),
    .ext_en(ext_en), .io_in(IO_IN));
  initial begin
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strap mask in direction word positions
  function automatic logic [7:0] fm(input integer p);
    fm = {3'h0, GROUP_A_FORCE_OUT_STRAP[p], GROUP_C_HIGH_FORCE_OUT_STRAP[p],
      1'b0, GROUP_B_FORCE_OUT_STRAP[p], GROUP_C_LOW_FORCE_OUT_STRAP[p]};
  endfunction
  // one single ahb transfer, zero waits not assumed
  task automatic xf(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    @(posedge CLOCK);
    while (HREADYOUT !== 1'b1) @(posedge CLOCK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLOCK);
    while (HREADYOUT !== 1'b1) @(posedge CLOCK);
    q = HRDATA;
  endtask
  // warm reset held three cycles so retention can be watched
  task automatic rst(input logic cold, input logic ret);
    if (cold) begin
      RST_N <= 1'b0;
      {GROUP_A_FORCE_OUT_STRAP, GROUP_B_FORCE_OUT_STRAP,
        GROUP_C_LOW_FORCE_OUT_STRAP, GROUP_C_HIGH_FORCE_OUT_STRAP}
        <= 16'($random(seed));
    end else begin
      WARM_RST_N <= 1'b0;
    end
    RESET_RETENTION_STRAP <= ret;
    repeat (cold ? 2 : 3) @(posedge CLOCK);
    RST_N <= 1'b1;
    WARM_RST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    for (int p = 0; p < 4; p++) begin
      if (cold || !ret) begin
        ctl[p] = 8'h1B & ~fm(p);
        dat[p] = 24'h000000;
      end
    end
  endtask
  task automatic wr_all;
    logic [31:0] c, o;
    for (int p = 0; p < 4; p++) begin
      c = $random(seed);
      o = $random(seed);
      xf(1'b1, 12'(4 * p), c, r);
      xf(1'b1, 12'(16 + 4 * p), o, r);
      ctl[p] = c[7:0] & 8'h1B & ~fm(p);
      dat[p] = o[23:0];
    end
    repeat (2) @(posedge CLOCK);
  endtask
  task automatic ports(input integer t);
    logic [23:0] oe, e;
    for (int p = 0; p < 4; p++) begin
      oe = {{4{!ctl[p][3]}}, {4{!ctl[p][0]}}, {8{!ctl[p][1]}},
        {8{!ctl[p][4]}}};
      e = oe & dat[p] | ~oe & (~ext_en[p*24+:24] | ext[p*24+:24]);
      cmp(IO_OE[p*24+:24], oe);
      cmp(IO_OUT[p*24+:24] & oe, dat[p] & oe);
      xf(1'b0, 12'(4 * p), 32'h0, r);
      cmp(r, ctl[p]);
      xf(1'b0, 12'(32 + 4 * p), 32'h0, r);
      cmp(r, e);
    end
    $display("test %0d done", t);
  endtask
  initial begin
    seed = 49448;
    miscompares = 0;
    checked = 0;
    ext = {3{$random(seed)}};
    ext_en = {3{$random(seed)}};
    rst(1'b1, 1'b0);
    ports(1);
    wr_all;
    ports(2);
    rst(1'b0, 1'b1);
    ports(3);
    rst(1'b0, 1'b0);
    ports(4);
    wr_all;
    rst(1'b1, 1'b1);
    ports(5);
    xf(1'b0, 12'h100, 32'h0, r);
    cmp(r, 32'h0);
    xf(1'b0, 12'h030, 32'h0, r);
    cmp(r[0], RESET_RETENTION_STRAP);
    tally_and_finish;
  end
  // cut a hang short well past the expected run
  initial begin
    #50000;
    miscompares++;
    tally_and_finish;
  end
endmodule
bind pdr_top pdr_top_checker i_chk (.*);
